// ===== core/ctw_pkg.sv
// Constants and types for the training and leveling block.
// Assumes CA is double data rate on the memory clock and DQ is resolved outside.
package ctw_pkg;

	localparam int CA_W = 10;
	localparam int DQ_W = 32;
	localparam int DQ_NARROW_W = 16;

	localparam logic [7:0] MA_TRAIN_ENTRY = 8'h29;
	localparam logic [7:0] OP_TRAIN_ENTRY = 8'hA4;
	localparam logic [7:0] MA_TRAIN_EXIT = 8'h2A;
	localparam logic [7:0] OP_TRAIN_EXIT = 8'hA8;
	localparam logic [7:0] MA_TRAIN_REMAP = 8'h30;
	localparam logic [7:0] OP_TRAIN_REMAP = 8'hC0;
	localparam logic [7:0] MA_LEVEL_CTRL = 8'h02;
	localparam int LEVEL_BIT = 7;
	localparam logic [7:0] LEVEL_CTRL_RESET = 8'h00;
	localparam logic [3:0] MRW_OPCODE = 4'h0;

	// Phase one CA bits in DQ pair order
	localparam int MAP1_CA [0:7] = '{0, 1, 2, 3, 5, 6, 7, 8};
	localparam int MAP2_CA_LO = 4;
	localparam int MAP2_CA_HI = 9;
	localparam int MAP2_DQ_HI = 8;

	typedef enum logic [1:0] {
		CTW_NORMAL,
		CTW_PHASE1,
		CTW_PHASE2,
		CTW_LEVEL
	} ctw_mode_t;

	typedef struct packed {
		logic is_mrw;
		logic [7:0] addr;
		logic [7:0] data;
	} ctw_cmd_t;

	typedef struct packed {
		logic [DQ_W-1:0] level;
		logic [DQ_W-1:0] enable;
	} ctw_dq_t;

	typedef struct packed {
		logic training;
		logic remapped;
		logic leveling;
	} ctw_status_t;

endpackage : ctw_pkg

// ===== core/ctw_core.sv
// Device-side CA training and write leveling logic.
// Assumes ck, cs_n, ca come from the controller; DQ pin resolved outside from enable.
`timescale 1ns/1ps
`default_nettype none
module ctw_core (
	// System clock and reset
	input wire logic clk,
	input wire logic rst,
	// Memory link
	input wire logic ck,
	input wire logic cs_n,
	input wire logic [ctw_pkg::CA_W-1:0] ca,
	input wire logic dqs_t,
	output var ctw_pkg::ctw_dq_t dq,
	// Configuration and status, system clock
	input wire logic wide_cfg,
	output var ctw_pkg::ctw_status_t status
);
	import ctw_pkg::*;

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic ctw_cmd_t decode_cmd(input logic [CA_W-1:0] rise, input logic [CA_W-1:0] fall);
		ctw_cmd_t c;
		c.is_mrw = (rise[3:0] == MRW_OPCODE);
		c.addr = {fall[1:0], rise[9:4]};
		c.data = fall[9:2];
		return c;
	endfunction : decode_cmd

	function automatic logic is_cmd(input ctw_cmd_t c, input logic [7:0] a, input logic [7:0] d);
		return c.is_mrw && (c.addr == a) && (c.data == d);
	endfunction : is_cmd

	// ----------------------------------------
	// Link capture
	// ----------------------------------------
	logic [CA_W-1:0] ca_rise;
	logic sel_rise;
	ctw_cmd_t cmd;
	logic cmd_hit;
	logic hit_entry;
	logic hit_exit;
	logic hit_remap;
	logic hit_level;
	ctw_mode_t mode;
	logic [7:0] leveling_control_mode_reg;
	logic [DQ_W-1:0] dq_train;
	logic lvl_sample;
	logic [2:0] wide_sync;
	logic wide;
	logic [DQ_W-1:0] width_mask;

	// Sample CA and select at the rising edge
	always_ff @(posedge ck or posedge rst) begin
		if (rst) begin
			ca_rise <= '0;
			sel_rise <= 1'b0;
		end else begin
			ca_rise <= ca;
			sel_rise <= ~cs_n;
		end
	end

	assign cmd = decode_cmd(ca_rise, ca);
	assign cmd_hit = sel_rise;
	assign hit_entry = cmd_hit && is_cmd(cmd, MA_TRAIN_ENTRY, OP_TRAIN_ENTRY);
	assign hit_exit = cmd_hit && is_cmd(cmd, MA_TRAIN_EXIT, OP_TRAIN_EXIT);
	assign hit_remap = cmd_hit && is_cmd(cmd, MA_TRAIN_REMAP, OP_TRAIN_REMAP);
	assign hit_level = cmd_hit && cmd.is_mrw && (cmd.addr == MA_LEVEL_CTRL);

	// Width select crossing into the falling-edge domain
	always_ff @(negedge ck or posedge rst) begin
		if (rst) begin
			wide_sync <= '0;
			wide <= 1'b0;
		end else begin
			wide_sync <= {wide_sync[1:0], wide_cfg};
			if (wide_sync[1] == wide_sync[2]) begin
				wide <= wide_sync[2];
			end
		end
	end

	// ----------------------------------------
	// Mode control
	// ----------------------------------------
	// Edge driven only, no period counting
	always_ff @(negedge ck or posedge rst) begin
		if (rst) begin
			mode <= CTW_NORMAL;
		end else begin
			case (mode)
				CTW_NORMAL: begin
					if (hit_entry) begin
						mode <= CTW_PHASE1;
					end else if (hit_level && cmd.data[LEVEL_BIT]) begin
						mode <= CTW_LEVEL;
					end
				end
				CTW_PHASE1: begin
					if (hit_exit) begin
						mode <= CTW_NORMAL;
					end else if (hit_remap) begin
						mode <= CTW_PHASE2;
					end
				end
				CTW_PHASE2: begin
					if (hit_exit) begin
						mode <= CTW_NORMAL;
					end
				end
				CTW_LEVEL: begin
					if (hit_level && !cmd.data[LEVEL_BIT]) begin
						mode <= CTW_NORMAL;
					end
				end
				default: begin
					mode <= CTW_NORMAL;
				end
			endcase
		end
	end

	always_ff @(negedge ck or posedge rst) begin
		if (rst) begin
			leveling_control_mode_reg <= LEVEL_CTRL_RESET;
		end else if (hit_level && (mode == CTW_NORMAL || mode == CTW_LEVEL)) begin
			leveling_control_mode_reg <= cmd.data;
		end
	end

	// ----------------------------------------
	// Training data
	// ----------------------------------------
	// Loaded at falling edge after each select in phase one or phase two
	always_ff @(negedge ck or posedge rst) begin
		if (rst) begin
			dq_train <= '0;
		end else if (cmd_hit && (mode == CTW_PHASE1 || mode == CTW_PHASE2)) begin
			dq_train <= '0;
			if (mode == CTW_PHASE1) begin
				for (int i = 0; i < 8; i++) begin
					dq_train[2*i] <= ca_rise[MAP1_CA[i]];
					dq_train[2*i+1] <= ca[MAP1_CA[i]];
				end
			end else begin
				dq_train[0] <= ca_rise[MAP2_CA_LO];
				dq_train[1] <= ca[MAP2_CA_LO];
				dq_train[MAP2_DQ_HI] <= ca_rise[MAP2_CA_HI];
				dq_train[MAP2_DQ_HI+1] <= ca[MAP2_CA_HI];
			end
		end
	end

	// ----------------------------------------
	// Leveling feedback
	// ----------------------------------------
	// Clock sampled by strobe
	always_ff @(posedge dqs_t or posedge rst) begin
		if (rst) begin
			lvl_sample <= 1'b0;
		end else begin
			lvl_sample <= ck;
		end
	end

	assign width_mask = wide ? {DQ_W{1'b1}} : {{(DQ_W-DQ_NARROW_W){1'b0}}, {DQ_NARROW_W{1'b1}}};

	always_comb begin
		dq.level = '0;
		dq.enable = '0;
		if (mode == CTW_PHASE1 || mode == CTW_PHASE2) begin
			dq.level = dq_train & width_mask;
			dq.enable = width_mask;
		end else if (mode == CTW_LEVEL) begin
			// Previous sample shown until first strobe
			dq.level = {DQ_W{lvl_sample}} & width_mask;
			dq.enable = width_mask;
		end
	end

	// ----------------------------------------
	// Status crossing
	// ----------------------------------------
	logic [2:0] st_train;
	logic [2:0] st_remap;
	logic [2:0] st_level;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_train <= '0;
			st_remap <= '0;
			st_level <= '0;
		end else begin
			st_train <= {st_train[1:0], (mode == CTW_PHASE1 || mode == CTW_PHASE2)};
			st_remap <= {st_remap[1:0], (mode == CTW_PHASE2)};
			st_level <= {st_level[1:0], (mode == CTW_LEVEL)};
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			status <= '0;
		end else begin
			if (st_train[1] == st_train[2]) begin
				status.training <= st_train[2];
			end
			if (st_remap[1] == st_remap[2]) begin
				status.remapped <= st_remap[2];
			end
			if (st_level[1] == st_level[2]) begin
				status.leveling <= st_level[2];
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_entry_mode: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_NORMAL && hit_entry) |=> (mode == CTW_PHASE1))
		else $error("entry command did not start training");

	a_exit_release: assert property (@(negedge ck) disable iff (rst)
		((mode == CTW_PHASE1 || mode == CTW_PHASE2) && hit_exit) |=> (dq.enable == '0 && mode == CTW_NORMAL))
		else $error("exit did not release DQ");

	a_remap_mode: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE1 && hit_remap && !hit_exit) |=> (mode == CTW_PHASE2))
		else $error("remap did not enter phase two");

	a_phase1_map: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE1 && cmd_hit && !hit_exit && !hit_remap)
		|=> (dq_train[1] == $past(ca[0]) && dq_train[14] == $past(ca_rise[8])))
		else $error("phase one DQ map wrong");

	a_phase2_map: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE2 && cmd_hit && !hit_exit)
		|=> (dq_train[8] == $past(ca_rise[9]) && dq_train[1] == $past(ca[4]) && dq_train[7:2] == '0))
		else $error("phase two DQ map wrong");

	a_unused_driven: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE2) |-> (dq.enable[DQ_NARROW_W-1:0] == {DQ_NARROW_W{1'b1}}))
		else $error("training DQ not driven");

	a_level_entry: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_NORMAL && hit_level && cmd.data[LEVEL_BIT] && !hit_entry) |=> (mode == CTW_LEVEL))
		else $error("leveling not entered");

	a_level_feedback: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_LEVEL && wide) |-> (dq.level == {DQ_W{lvl_sample}} && dq.enable == {DQ_W{1'b1}}))
		else $error("leveling feedback not on all bits");

	a_train_ignore: assert property (@(negedge ck) disable iff (rst)
		((mode == CTW_PHASE1 || mode == CTW_PHASE2) && hit_level) |=> $stable(leveling_control_mode_reg))
		else $error("mode register changed in training");

	c_full_training: cover property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE2) ##[1:50] (mode == CTW_NORMAL));
	c_repeat_cal: cover property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE1 && cmd_hit) ##1 (mode == CTW_PHASE1 && cmd_hit));
	c_level_rise: cover property (@(negedge ck) disable iff (rst)
		(mode == CTW_LEVEL && !lvl_sample) ##[1:50] (mode == CTW_LEVEL && lvl_sample));
	c_narrow_level: cover property (@(negedge ck) disable iff (rst)
		(mode == CTW_LEVEL && !wide && lvl_sample));
	c_remap_entry: cover property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE1 && hit_remap) ##1 (mode == CTW_PHASE2));

	a_phase1_driven: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_PHASE1) |-> (dq.enable[DQ_NARROW_W-1:0] == {DQ_NARROW_W{1'b1}}))
		else $error("phase one DQ not driven");

	a_normal_released: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_NORMAL) |-> (dq.enable == '0 && dq.level == '0))
		else $error("DQ driven in normal mode");

	a_level_exit: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_LEVEL && hit_level && !cmd.data[LEVEL_BIT]) |=> (mode == CTW_NORMAL))
		else $error("leveling not left");

	a_level_bit: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_LEVEL) |-> leveling_control_mode_reg[LEVEL_BIT])
		else $error("leveling mode without its mode bit");

	a_narrow_feedback: assert property (@(negedge ck) disable iff (rst)
		(mode == CTW_LEVEL && !wide)
		|-> (dq.enable[DQ_W-1:DQ_NARROW_W] == '0 && dq.enable[DQ_NARROW_W-1:0] == {DQ_NARROW_W{1'b1}}
		&& dq.level[DQ_NARROW_W-1:0] == {DQ_NARROW_W{lvl_sample}}))
		else $error("narrow leveling feedback wrong");

	a_level_sample: assert property (@(posedge dqs_t) disable iff (rst)
		1'b1 |=> (lvl_sample == $past(ck)))
		else $error("strobe did not sample the clock");

endmodule : ctw_core
`default_nettype wire

// ===== bench/ctw_ctrl_model.sv
// Controller model: link clock, commands and strobe.
// Assumes the device samples CA on both ck edges.
`timescale 1ns/1ps
`default_nettype none
module ctw_ctrl_model (
	// Link outputs
	output var logic ck,
	output var logic cs_n,
	output var logic [ctw_pkg::CA_W-1:0] ca,
	output var logic dqs_t
);
	import ctw_pkg::*;
	realtime stretch = 0.0;
	realtime half = 3.0;
	initial begin
		ck = 1'b0;
		cs_n = 1'b1;
		ca = '0;
		dqs_t = 1'b0;
	end
	// free clock, unrelated phase, one high phase may stretch
	initial begin
		#1.3;
		forever begin
			#3 ck = ~ck;
			half = 3.0 + stretch;
			stretch = 0.0;
			#(half) ck = ~ck;
		end
	end
	// stretch one high phase while deselected
	task automatic stall(input realtime d);
		stretch = d;
		@(posedge ck);
		@(posedge ck);
		#1;
	endtask : stall
	task automatic cmd(input logic [CA_W-1:0] r, input logic [CA_W-1:0] f);
		ca = r;
		@(posedge ck);
		#1 cs_n = 1'b0;
		@(posedge ck);
		#1 cs_n = 1'b1;
		ca = f;
		@(posedge ck);
		#1;
	endtask : cmd
	task automatic strobe(input int d);
		@(posedge ck);
		#(d) dqs_t = 1'b1;
		#1 dqs_t = 1'b0;
	endtask : strobe
endmodule : ctw_ctrl_model
`default_nettype wire

// ===== bench/tb_top.sv
// Testbench for the training and leveling block.
// Assumes the controller model makes ck and all link inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ctw_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wide_cfg = 1'b1;
	logic ck;
	logic cs_n;
	logic dqs_t;
	logic [CA_W-1:0] ca;
	ctw_dq_t dq;
	ctw_status_t status;
	int failures = 0;
	int n_tests = 0;
	always #50 clk = ~clk;
	ctw_core ctw_core_inst (.clk(clk), .rst(rst), .ck(ck), .cs_n(cs_n), .ca(ca), .dqs_t(dqs_t),
		.dq(dq), .wide_cfg(wide_cfg), .status(status));
	ctw_ctrl_model ctw_ctrl_model_inst (.ck(ck), .cs_n(cs_n), .ca(ca), .dqs_t(dqs_t));
	// ---------------------------------
	// Helpers
	// ---------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [9:0] r, input logic [9:0] f);
		ctw_ctrl_model_inst.cmd(r, f);
	endtask : cmd
	function automatic logic [31:0] map1(input logic [9:0] r, input logic [9:0] f);
		int m [8];
		logic [31:0] e;
		m = '{0, 1, 2, 3, 5, 6, 7, 8};
		e = '0;
		for (int i = 0; i < 8; i++) begin
			e[2*i] = r[m[i]];
			e[2*i+1] = f[m[i]];
		end
		return e;
	endfunction : map1
	task automatic conclude();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// ---------------------------------
	// Scenarios
	// ---------------------------------
	task automatic t_phase1();
		cmd(10'h290, 10'h290);
		chk(dq.enable, 32'hFFFFFFFF);
		chk(dq.level, 32'h0);
		ctw_ctrl_model_inst.stall(4.5);
		cmd(10'h0F3, 10'h30C);
		chk(dq.level, map1(10'h0F3, 10'h30C));
		cmd(10'h155, 10'h2AA);
		chk(dq.level, map1(10'h155, 10'h2AA));
		@(negedge clk);
		chk(dq.level, map1(10'h155, 10'h2AA));
		repeat (6) @(negedge clk);
		chk({29'h0, status}, 32'h4);
	endtask : t_phase1
	task automatic t_phase2();
		cmd(10'h300, 10'h300);
		cmd(10'h020, 10'h200);
		chk(dq.enable, 32'hFFFFFFFF);
		chk(dq.level, 32'h00000200);
		cmd(10'h2F1, 10'h1CE);
		chk(dq.level, 32'h00000101);
		repeat (6) @(negedge clk);
		chk({29'h0, status}, 32'h6);
	endtask : t_phase2
	task automatic t_exit();
		cmd(10'h2A0, 10'h2A0);
		chk(dq.enable, 32'h0);
		cmd(10'h2A0, 10'h2A0);
		chk(dq.enable, 32'h0);
		repeat (6) @(negedge clk);
		chk({29'h0, status}, 32'h0);
		cmd(10'h155, 10'h2AA);
		chk(dq.enable, 32'h0);
	endtask : t_exit
	task automatic t_level();
		logic [31:0] mask;
		for (int w = 0; w < 2; w++) begin
			mask = (w == 1) ? 32'hFFFFFFFF : 32'h0000FFFF;
			@(negedge clk);
			wide_cfg = w[0];
			repeat (2) @(negedge clk);
			cmd(10'h020, 10'h200);
			chk(dq.enable, mask);
			// only strobes, swept late to early
			ctw_ctrl_model_inst.strobe(5);
			#1 chk(dq.level & dq.enable, 32'h0);
			ctw_ctrl_model_inst.strobe(1);
			#1 chk(dq.level & dq.enable, mask);
			repeat (6) @(negedge clk);
			chk({29'h0, status}, 32'h1);
			cmd(10'h020, 10'h000);
			chk(dq.enable, 32'h0);
		end
	endtask : t_level
	// ---------------------------------
	// Main sequence and watchdog
	// ---------------------------------
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk(dq.enable, 32'h0);
		chk({29'h0, status}, 32'h0);
		t_phase1();
		t_phase2();
		t_exit();
		t_level();
		conclude();
	end
	initial begin
		#100000;
		failures++;
		conclude();
	end
endmodule : tb_top
`default_nettype wire
